// >>> pcu_core_model.sv
/*
 * Core-side stand-in: retire counts, event pulses, platform timer.
 * Assumes the bench clock; it drives on the falling edge only.
 */
`timescale 1ns/1ps
module pcu_core_model #(
  parameter int NEV = 16
) (
  input wire logic clk_i,
  output logic [1:0] retire_o,
  output logic [NEV-1:0] event_o,
  output logic [63:0] mtime_o
);
  // ********
  // Traffic
  // ********
  logic [31:0] seed_reg = 32'h1d2c3b4a;
  initial begin
    retire_o = 2'h0;
    event_o = '0;
    // Low word wraps early so both timer halves move
    mtime_o = 64'h1_ffff_ff00;
  end
  always @(negedge clk_i) begin
    seed_reg = {seed_reg[30:0], seed_reg[31] ^ seed_reg[21] ^ seed_reg[1] ^ seed_reg[0]};
    retire_o <= seed_reg[1:0];
    event_o <= seed_reg[NEV+1:2];
    mtime_o <= mtime_o + 64'h1;
  end
endmodule

// >>> pcu_pkg.sv
/*
 * Constants and carrier types for the performance counter unit.
 * Assumes a 32-bit machine word and a 12-bit register address.
 */
package pcu_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [11:0] PCU_M_LO_BASE = 12'hb00;
  localparam logic [11:0] PCU_M_HI_BASE = 12'hb80;
  localparam logic [11:0] PCU_U_LO_BASE = 12'hc00;
  localparam logic [11:0] PCU_U_HI_BASE = 12'hc80;
  localparam logic [11:0] PCU_SEL_BASE = 12'h320;
  localparam logic [11:0] PCU_CNTEN_ADDR = 12'h306;
  localparam logic [4:0] PCU_HALT_IDX = 5'h00;
  // ****************************************
  // Slot layout and privilege codes
  // ****************************************
  localparam logic [4:0] PCU_CYCLE_IDX = 5'h00;
  localparam logic [4:0] PCU_TIME_IDX = 5'h01;
  localparam logic [4:0] PCU_RETIRE_IDX = 5'h02;
  localparam logic [4:0] PCU_FIRST_EVT = 5'h03;
  localparam int PCU_SLOTS = 32;
  localparam logic [1:0] PCU_PRIV_U = 2'h0;
  localparam logic [1:0] PCU_PRIV_S = 2'h1;
  localparam logic [1:0] PCU_PRIV_M = 2'h3;
  // ****************************************
  // Values after reset and response latency
  // ****************************************
  localparam logic [63:0] PCU_CNT_RESET = 64'h0;
  localparam logic [31:0] PCU_CTRL_RESET = 32'h0;
  localparam logic [1:0] PCU_SYNC_RESET = 2'h0;
  localparam int PCU_ACK_LAT = 1;

  typedef struct packed {
    logic valid;
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [1:0] priv;
  } pcu_csr_req_t;

  typedef struct packed {
    logic ack;
    logic illegal;
    logic [31:0] rdata;
  } pcu_csr_rsp_t;
endpackage

// >>> pcu_top.sv
/*
 * Performance counter unit for one hart: cycle, retire and event
 * counters, halves access, access enable and halt mask.
 * Assumes the core issues at most one register request per cycle
 * and that all inputs are synchronous to sys_clk_i.
 */
// What this block does
// - Cycle counter counts every core clock
// - Retire counter adds instructions retired
// - Cycle and retire counters are 64 bits
// - Counters start anywhere; writes load value
// - Write wins over same-instruction increment
// - Shared cycle counter writes seen by all
// - Twenty-nine event counters, slots 3 to 31
// - Selector picks event; zero means none
// - Unbuilt counters and selectors read zero
// - Counters keep legal values, up to 64
// - Low word bits 31-0, high 63-32
// - Access enable: cycle, timer, retire, events
// - Access enable never touches counters
// - Clear enable: lower read is illegal
// - Set enable: next lower level may read
// - User views are read-only counter copies
// - Time view copies platform timer halves
// - Access enable exists only with user
// - Halt mask only stops counting
// - Set halt bit stops that counter
// - Shared cycle halt bit seen by all
// - Absent halt mask acts as zero
`timescale 1ns/1ps
module pcu_top import pcu_pkg::*; #(
  parameter int NUM_EVT_IMPL = 29,
  parameter int CNT_W = 64,
  parameter int NUM_EVENTS = 16,
  parameter int SEL_W = 8,
  parameter int RET_W = 2,
  parameter bit HAS_S = 1'b1,
  parameter bit HAS_U = 1'b1,
  parameter bit HALT_IMPL = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire pcu_csr_req_t csr_req_i,
  output pcu_csr_rsp_t csr_rsp_o,
  input wire logic [RET_W-1:0] retire_count_i,
  input wire logic [NUM_EVENTS-1:0] event_i,
  input wire logic [63:0] mtime_i
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic slot_impl(input int idx);
    return idx == 0 || idx == 2 ||
      (idx >= 3 && idx < 3 + NUM_EVT_IMPL);
  endfunction

  function automatic logic [31:0] impl_mask();
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < PCU_SLOTS; i++) begin
      m[i] = slot_impl(i) || i == 1;
    end
    return m;
  endfunction

  function automatic logic evt_hit(input logic [SEL_W-1:0] sel,
                                   input logic [NUM_EVENTS-1:0] ev);
    logic hit;
    hit = 1'b0;
    for (int k = 1; k <= NUM_EVENTS; k++) begin
      if (int'(sel) == k) begin
        hit = ev[k-1];
      end
    end
    return hit;
  endfunction

  localparam logic [31:0] LEGAL_MASK = impl_mask();
  localparam logic [63:0] EVT_MASK = (CNT_W >= 64) ? 64'hffffffffffffffff :
    ((64'h1 << CNT_W) - 64'h1);
  localparam logic [SEL_W-1:0] MAX_SEL = SEL_W'(NUM_EVENTS);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= PCU_SYNC_RESET;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************
  // State
  // ****************************************
  logic [63:0] cnt_reg [PCU_SLOTS];
  logic [SEL_W-1:0] sel_reg [PCU_SLOTS];
  logic [31:0] cnten_reg;
  logic [31:0] halt_reg;
  logic [31:0] halt_eff;
  logic [31:0] cnten_eff;
  pcu_csr_rsp_t rsp_reg;

  // Halt mask gates counting only; timer bit never stored
  assign halt_eff = HALT_IMPL ? (halt_reg & LEGAL_MASK & ~32'h2) : 32'h0;
  assign cnten_eff = HAS_U ? (cnten_reg & LEGAL_MASK) : 32'h0;

  // ****************************************
  // Address decode
  // ****************************************
  logic [4:0] idx;
  logic [6:0] grp;
  logic is_m;
  logic lower_ok;
  logic ill;
  logic [31:0] rd_data;
  logic wr_fire;
  logic [31:0] wr_lo_vec;
  logic [31:0] wr_hi_vec;
  logic [31:0] wr_sel_vec;
  logic wr_cnten;
  logic wr_halt;

  assign idx = csr_req_i.addr[4:0];
  assign grp = csr_req_i.addr[11:5];
  assign is_m = csr_req_i.priv == PCU_PRIV_M;
  // Only the next implemented level below machine gets the views
  assign lower_ok = HAS_S ? (csr_req_i.priv == PCU_PRIV_S) :
    (HAS_U && csr_req_i.priv == PCU_PRIV_U);

  always_comb begin
    ill = 1'b1;
    rd_data = 32'h0;
    if (grp == PCU_M_LO_BASE[11:5] && idx != PCU_TIME_IDX) begin
      ill = !is_m;
      rd_data = cnt_reg[idx][31:0];
    end else if (grp == PCU_M_HI_BASE[11:5] && idx != PCU_TIME_IDX) begin
      ill = !is_m;
      rd_data = cnt_reg[idx][63:32];
    end else if (grp == PCU_U_LO_BASE[11:5] || grp == PCU_U_HI_BASE[11:5]) begin
      // Views are read-only; a write is illegal at any level
      ill = csr_req_i.we || !(is_m || (cnten_eff[idx] && lower_ok));
      if (idx == PCU_TIME_IDX) begin
        rd_data = grp[2] ? mtime_i[63:32] : mtime_i[31:0];
      end else begin
        rd_data = grp[2] ? cnt_reg[idx][63:32] : cnt_reg[idx][31:0];
      end
    end else if (grp == PCU_SEL_BASE[11:5] && idx == PCU_HALT_IDX) begin
      ill = !is_m;
      rd_data = halt_eff;
    end else if (grp == PCU_SEL_BASE[11:5] && idx >= PCU_FIRST_EVT) begin
      ill = !is_m;
      rd_data = 32'(sel_reg[idx]);
    end else if (csr_req_i.addr == PCU_CNTEN_ADDR && HAS_U) begin
      ill = !is_m;
      rd_data = cnten_eff;
    end
  end

  assign wr_fire = csr_req_i.valid && csr_req_i.we && !ill;
  assign wr_cnten = wr_fire && csr_req_i.addr == PCU_CNTEN_ADDR;
  assign wr_halt = wr_fire && grp == PCU_SEL_BASE[11:5] &&
    idx == PCU_HALT_IDX;

  always_comb begin
    wr_lo_vec = 32'h0;
    wr_hi_vec = 32'h0;
    wr_sel_vec = 32'h0;
    if (wr_fire && grp == PCU_M_LO_BASE[11:5]) begin
      wr_lo_vec[idx] = 1'b1;
    end
    if (wr_fire && grp == PCU_M_HI_BASE[11:5]) begin
      wr_hi_vec[idx] = 1'b1;
    end
    if (wr_fire && grp == PCU_SEL_BASE[11:5] && idx >= PCU_FIRST_EVT) begin
      wr_sel_vec[idx] = 1'b1;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Touching these never alters a counter value
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnten_reg <= PCU_CTRL_RESET;
    end else if (wr_cnten) begin
      cnten_reg <= csr_req_i.wdata & LEGAL_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      halt_reg <= PCU_CTRL_RESET;
    end else if (wr_halt) begin
      // Single copy: every hart on this core sees the cycle bit
      halt_reg <= csr_req_i.wdata & LEGAL_MASK & ~32'h2;
    end
  end

  // ****************************************
  // Counter slots
  // ****************************************
  for (genvar g = 0; g < PCU_SLOTS; g++) begin : g_slot
    if (slot_impl(g)) begin : g_on
      logic [63:0] inc_val;
      logic [63:0] sum;
      logic [63:0] wmask;

      if (g == 0) begin : g_cyc
        assign inc_val = 64'h1;
      end else if (g == 2) begin : g_ret
        assign inc_val = 64'(retire_count_i);
      end else begin : g_evt
        // Selector zero never matches an event
        assign inc_val = evt_hit(sel_reg[g], event_i) ? 64'h1 : 64'h0;
      end

      assign wmask = (g < 3) ? 64'hffffffffffffffff : EVT_MASK;
      // Natural carry-out drop gives a silent wrap
      assign sum = (cnt_reg[g] + (halt_eff[g] ? 64'h0 : inc_val)) & wmask;

      // Reset value is a convenience; software must not rely on it
      always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          cnt_reg[g] <= PCU_CNT_RESET;
        end else if (wr_lo_vec[g]) begin
          // Write replaces this cycle's increment entirely
          cnt_reg[g] <= {cnt_reg[g][63:32], csr_req_i.wdata} & wmask;
        end else if (wr_hi_vec[g]) begin
          cnt_reg[g] <= {csr_req_i.wdata, cnt_reg[g][31:0]} & wmask;
        end else begin
          cnt_reg[g] <= sum;
        end
      end

      if (g >= 3) begin : g_sel
        always_ff @(posedge sys_clk_i or negedge rst_n) begin
          if (!rst_n) begin
            sel_reg[g] <= '0;
          end else if (wr_sel_vec[g]) begin
            // Out-of-range codes fall back to no event
            sel_reg[g] <= (csr_req_i.wdata <= 32'(MAX_SEL)) ?
              csr_req_i.wdata[SEL_W-1:0] : '0;
          end
        end
      end else begin : g_nosel
        assign sel_reg[g] = '0;
      end
    end else begin : g_off
      assign cnt_reg[g] = 64'h0;
      assign sel_reg[g] = '0;
    end
  end

  // ****************************************
  // Response
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack <= csr_req_i.valid;
      rsp_reg.illegal <= csr_req_i.valid && ill;
      rsp_reg.rdata <= (csr_req_i.valid && !ill) ? rd_data : 32'h0;
    end
  end
  assign csr_rsp_o = rsp_reg;

  // ****************************************
  // Checks
  // ****************************************
  property p_cycle_inc;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (!halt_eff[0] && !wr_lo_vec[0] && !wr_hi_vec[0])
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 64'h1;
  endproperty
  a_cycle_inc: assert property (p_cycle_inc) else $error("cycle count missed a clock");

  property p_retire_inc;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (!halt_eff[2] && !wr_lo_vec[2] && !wr_hi_vec[2])
      |=> cnt_reg[2] == $past(cnt_reg[2]) + 64'($past(retire_count_i));
  endproperty
  a_retire_inc: assert property (p_retire_inc) else $error("retire count wrong");

  property p_write_lo;
    @(posedge sys_clk_i) disable iff (!rst_n)
      wr_lo_vec[2] |=> cnt_reg[2][31:0] == $past(csr_req_i.wdata) &&
        cnt_reg[2][63:32] == $past(cnt_reg[2][63:32]);
  endproperty
  a_write_lo: assert property (p_write_lo) else $error("low write not loaded");

  property p_write_hi;
    @(posedge sys_clk_i) disable iff (!rst_n)
      wr_hi_vec[0] |=> cnt_reg[0][63:32] == $past(csr_req_i.wdata) &&
        cnt_reg[0][31:0] == $past(cnt_reg[0][31:0]);
  endproperty
  a_write_hi: assert property (p_write_hi) else $error("high write not loaded");

  property p_halt_hold;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (halt_eff[0] && !wr_lo_vec[0] && !wr_hi_vec[0]) [*2]
      |-> cnt_reg[0] == $past(cnt_reg[0], 1);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halted counter moved");

  property p_user_denied;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (csr_req_i.valid && csr_req_i.priv != PCU_PRIV_M &&
       grp == PCU_U_LO_BASE[11:5] && !cnten_eff[idx])
      |=> csr_rsp_o.ack && csr_rsp_o.illegal && csr_rsp_o.rdata == 32'h0;
  endproperty
  a_user_denied: assert property (p_user_denied) else $error("disabled view readable");

  property p_time_view;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (csr_req_i.valid && is_m && !csr_req_i.we &&
       csr_req_i.addr == (PCU_U_LO_BASE | 12'(PCU_TIME_IDX)))
      |=> csr_rsp_o.rdata == $past(mtime_i[31:0]);
  endproperty
  a_time_view: assert property (p_time_view) else $error("time view mismatch");

  property p_ack;
    @(posedge sys_clk_i) disable iff (!rst_n)
      csr_req_i.valid |-> ##1 csr_rsp_o.ack ##0 ($past(ill) == csr_rsp_o.illegal);
  endproperty
  a_ack: assert property (p_ack) else $error("response missing");

  property p_timer_halt_zero;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (csr_req_i.valid && is_m && !csr_req_i.we &&
       grp == PCU_SEL_BASE[11:5] && idx == PCU_HALT_IDX)
      |=> !csr_rsp_o.illegal && !csr_rsp_o.rdata[1];
  endproperty
  a_timer_halt_zero: assert property (p_timer_halt_zero) else $error("timer halt bit set");

  property p_sel_zero;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (sel_reg[3] == '0 && !wr_lo_vec[3] && !wr_hi_vec[3])
      |=> cnt_reg[3] == $past(cnt_reg[3]);
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("idle event counter moved");

  property p_evt_count;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (!halt_eff[3] && sel_reg[3] == SEL_W'(1) && !wr_lo_vec[3] && !wr_hi_vec[3])
      |=> cnt_reg[3] == $past(cnt_reg[3]) + 64'($past(event_i[0]));
  endproperty
  a_evt_count: assert property (p_evt_count) else $error("event counter missed event");

  property p_cnten_no_touch;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_cnten && !halt_eff[0])
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 64'h1;
  endproperty
  a_cnten_no_touch: assert property (p_cnten_no_touch) else $error("enable write moved counter");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (cnt_reg[0] == 64'hffffffffffffffff && !halt_eff[0] && !wr_lo_vec[0] && !wr_hi_vec[0])
      |=> cnt_reg[0] == 64'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("cycle count did not wrap");

  property p_view_allowed;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (HAS_S && csr_req_i.valid && !csr_req_i.we && csr_req_i.priv == PCU_PRIV_S &&
       grp == PCU_U_LO_BASE[11:5] && cnten_eff[idx])
      |=> csr_rsp_o.ack && !csr_rsp_o.illegal;
  endproperty
  a_view_allowed: assert property (p_view_allowed) else $error("enabled view refused");
endmodule

// >>> perf_counter_unit_tb_top.sv
/*
 * Self-checking bench for the performance counter unit.
 * Assumes pcu_pkg and pcu_core_model; a shadow predicts every reply.
 */
`timescale 1ns/1ps
module perf_counter_unit_tb_top import pcu_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  pcu_csr_req_t req = '0;
  pcu_csr_rsp_t rsp;
  logic [1:0] ret;
  logic [15:0] ev;
  logic [63:0] mt;
  logic [63:0] sh0, sh2, sh3;
  logic [31:0] halt_sh, en_sh, sel_sh, seed, d;
  logic [33:0] exp_q;
  logic pend = 1'b0;
  logic armed = 1'b0;
  int failures = 0;
  int num_checks = 0;
  logic [11:0] adr [22] = '{12'hb00, 12'hb02, 12'hb03, 12'hb1f, 12'hb80, 12'hb82, 12'hb83, 12'hb01,
    12'hc00, 12'hc01, 12'hc02, 12'hc03, 12'hc80, 12'hc81, 12'hc82, 12'hc83,
    12'h306, 12'h320, 12'h323, 12'h33f, 12'h322, 12'h7ff};
  logic [1:0] pv [3] = '{PCU_PRIV_U, PCU_PRIV_S, PCU_PRIV_M};
  always #10 sys_clk_i = ~sys_clk_i;
  // Slot 31 left unbuilt so its read-zero behaviour is reachable
  pcu_top #(.NUM_EVT_IMPL(28)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .csr_req_i(req),
    .csr_rsp_o(rsp), .retire_count_i(ret), .event_i(ev), .mtime_i(mt));
  pcu_core_model core (.clk_i(sys_clk_i), .retire_o(ret), .event_o(ev), .mtime_o(mt));
  // ********
  // Prediction
  // ********
  function automatic logic [32:0] exp_rd(pcu_csr_req_t r);
    logic [4:0] n;
    logic [63:0] v;
    logic m;
    logic ill;
    logic [31:0] x;
    n = r.addr[4:0];
    m = (r.priv == PCU_PRIV_M);
    v = (n == 0) ? sh0 : (n == 2) ? sh2 : (n == 3) ? sh3 : (n == 1) ? mt : 64'h0;
    x = r.addr[7] ? v[63:32] : v[31:0];
    ill = 1'b0;
    case (r.addr[11:5])
      7'h58, 7'h5c: ill = !m || n == 1;
      7'h60, 7'h64: ill = r.we || !(m || (r.priv == PCU_PRIV_S && en_sh[n]));
      7'h19: begin
        ill = !m || n == 1 || n == 2;
        x = (n == 0) ? halt_sh : (n == 3) ? sel_sh : 32'h0;
      end
      default: begin
        ill = !(m && r.addr == PCU_CNTEN_ADDR);
        x = en_sh;
      end
    endcase
    return {ill, ill ? 32'h0 : x};
  endfunction
  function automatic logic [63:0] put(logic [63:0] v, logic hi, logic [31:0] w);
    return hi ? {w, v[31:0]} : {v[63:32], w};
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge sys_clk_i) begin
    logic [32:0] e;
    logic [4:0] n;
    logic wr;
    e = exp_rd(req);
    n = req.addr[4:0];
    wr = req.valid && req.we && !e[32];
    pend <= req.valid;
    exp_q <= {1'b1, e};
    if (!reset_n_i) begin
      halt_sh <= 32'h0;
      en_sh <= 32'h0;
      sel_sh <= 32'h0;
    end else begin
      sh0 <= halt_sh[0] ? sh0 : sh0 + 64'h1;
      sh2 <= halt_sh[2] ? sh2 : sh2 + ret;
      sh3 <= (halt_sh[3] || sel_sh == 0) ? sh3 : sh3 + ev[sel_sh[4:0] - 5'h1];
      if (wr && req.addr[11:5] == 7'h19 && n == 0) halt_sh <= req.wdata & 32'h7ffffffd;
      if (wr && req.addr[11:5] == 7'h19 && n == 3) sel_sh <= (req.wdata <= 32'h10) ? req.wdata : 32'h0;
      if (wr && req.addr == PCU_CNTEN_ADDR) en_sh <= req.wdata & 32'h7fffffff;
      if (wr && (req.addr[11:5] == 7'h58 || req.addr[11:5] == 7'h5c)) begin
        // Write replaces the same-edge increment
        if (n == 0) sh0 <= put(sh0, req.addr[7], req.wdata);
        if (n == 2) sh2 <= put(sh2, req.addr[7], req.wdata);
        if (n == 3) sh3 <= put(sh3, req.addr[7], req.wdata);
      end
    end
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  always @(negedge sys_clk_i) begin
    if (reset_n_i && armed) begin
      if (pend && exp_q[32]) check(rsp, exp_q);
      else check(rsp, pend ? exp_q : 34'h0);
    end
  end
  // ********
  // Stimulus
  // ********
  task automatic csr(input logic we, input logic [11:0] a, input logic [31:0] w, input logic [1:0] p);
    @(negedge sys_clk_i);
    req <= '{valid: 1'b1, we: we, addr: a, wdata: w, priv: p};
  endtask
  task automatic idle(input int k);
    repeat (k) begin
      @(negedge sys_clk_i);
      req.valid <= 1'b0;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    seed = 32'h11248;
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    idle(4);
    // Counters start near the top so the wrap shows
    for (int k = 0; k < 4; k++) if (k != 1) begin
      csr(1'b1, PCU_M_HI_BASE | 12'(k), 32'hffffffff, PCU_PRIV_M);
      csr(1'b1, PCU_M_LO_BASE | 12'(k), 32'hfffffff0, PCU_PRIV_M);
    end
    idle(2);
    armed = 1'b1;
    for (int s = 0; s < 18; s++) begin
      csr(1'b1, 12'h323, 32'(s), PCU_PRIV_M);
      csr(1'b0, 12'h323, 32'h0, PCU_PRIV_M);
      for (int j = 0; j < 7; j++) csr(1'b0, adr[j], 32'h0, PCU_PRIV_M);
    end
    for (int e = 0; e < 2; e++) begin
      csr(1'b1, PCU_CNTEN_ADDR, e ? 32'hffffffff : 32'h0, PCU_PRIV_M);
      for (int p = 0; p < 3; p++)
        for (int j = 8; j < 16; j++) csr(j == 9, adr[j], 32'h5, pv[p]);
    end
    csr(1'b1, 12'h320, 32'hffffffff, PCU_PRIV_M);
    for (int j = 0; j < 20; j++) csr(1'b0, adr[j], 32'h0, PCU_PRIV_M);
    csr(1'b1, 12'h320, 32'h0, PCU_PRIV_M);
    repeat (600) begin
      seed = lfsr(seed);
      d = lfsr(seed);
      csr(seed[0] & seed[1], adr[seed[12:8] % 5'd22], {d[7:0], d[31:8]}, pv[seed[3:2] % 2'd3]);
      if (seed[4]) idle(1);
    end
    idle(4);
    end_sim();
  end
endmodule
